// >>> logic/emi_map.svh
/*
  Register offsets, field positions, reset values and sizes of the
  external data memory interface. Assumes inclusion by emi_onchip_xdata_ram, emi_top and tb.
*/
`ifndef EMI_MAP_SVH
`define EMI_MAP_SVH

// Register byte addresses on the AXI4-Lite slave
`define EMI_OFF_PAGE 8'h00
`define EMI_OFF_PTR_HI 8'h04
`define EMI_OFF_PTR_LO 8'h08
`define EMI_OFF_IDX0 8'h0C
`define EMI_OFF_IDX1 8'h10
`define EMI_OFF_CFG 8'h14
`define EMI_OFF_CMD 8'h18
`define EMI_OFF_STAT 8'h1C

// Configuration field positions
`define EMI_CFG_MUX 0
`define EMI_CFG_MODE_LO 1
`define EMI_CFG_LCD 3
`define EMI_CFG_PULSE_LO 4
`define EMI_CFG_SETUP_LO 8
`define EMI_CFG_HOLD_LO 10
`define EMI_CFG_ALE_LO 12
`define EMI_CFG_W 14
`define EMI_CFG_RST 14'h0000

// Command field positions
`define EMI_CMD_DIR 8
`define EMI_CMD_FORM_LO 9

// Status field positions
`define EMI_ST_BUSY 0
`define EMI_ST_OFF 1
`define EMI_ST_REFUSED 2
`define EMI_ST_RDATA_LO 8

// Memory sizes and reset values
`define EMI_ONCHIP_XDATA_RAM_AW 13
`define EMI_ONCHIP_XDATA_RAM_WORDS 8192
`define EMI_ONCHIP_TOP 16'h2000
`define EMI_PAGE_RST 8'h00
`define EMI_PIN_PARK 8'hFF

// Port 3 strobe bit positions
`define EMI_P3_ALE 5
`define EMI_P3_RD 6
`define EMI_P3_WR 7

`endif

// >>> logic/emi_pkg.sv
/*
  Types of the external data memory interface.
  Assumes the map header is on the include path.
*/
package emi_pkg;

  typedef enum logic [1:0] {
    EMI_MM_ONCHIP,
    EMI_MM_SPLIT_NOBANK,
    EMI_MM_SPLIT_BANK,
    EMI_MM_OFFCHIP
  } emi_mode_t;

  typedef enum logic [1:0] {
    EMI_FORM_PTR,
    EMI_FORM_IDX0,
    EMI_FORM_IDX1,
    EMI_FORM_SPARE
  } emi_form_t;

  typedef enum {
    EMI_IDLE,
    EMI_ON_ACC,
    EMI_ON_WAIT,
    EMI_ALE,
    EMI_ALE_HOLD,
    EMI_SETUP,
    EMI_STROBE,
    EMI_HOLD
  } emi_state_t;

  // One port of eight pins, drivers enabled low
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe_n;
  } emi_pin_t;

  // A move being carried out
  typedef struct packed {
    logic [15:0] addr;
    logic write;
    logic [7:0] wdata;
    logic offchip;
    logic drive_hi;
  } emi_move_t;

endpackage : emi_pkg

// >>> logic/emi_onchip_xdata_ram.sv
/*
  On-chip external data RAM, 8 kB, one port, registered read data.
  Assumes one access per cycle issued by emi_top.
*/
`timescale 1ns/100ps
`include "emi_map.svh"

module emi_onchip_xdata_ram (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic en,
  input wire logic we,
  input wire logic [`EMI_ONCHIP_XDATA_RAM_AW-1:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);

  logic [7:0] mem [0:`EMI_ONCHIP_XDATA_RAM_WORDS-1];
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  always_comb begin
    rdata_next = rdata_reg;
    if (en && !we) begin
      rdata_next = mem[addr];
    end
  end

  // Array holds no reset so it maps onto a RAM macro
  always_ff @(posedge clk) begin
    if (en && we) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign rdata = rdata_reg;

endmodule : emi_onchip_xdata_ram

// >>> logic/emi_top.sv
/*
  External data memory interface: effective address forming, on-chip
  8 kB data RAM and an off-chip bus on ports 3 to 6, reached over AXI4-Lite.
  Assumes synchronous pin inputs, 100 MHz clk, the port mux outside
  honouring pins_owned and the per-pin driver enables.
*/
// What this block does
// - On-chip 8 kB data RAM sits in the external data address space.
// - Moves go to on-chip data RAM by default.
// - Pointer form uses the full 16-bit data pointer as address.
// - Data pointer reads and writes as separate high and low bytes.
// - Indirect form: page register high byte, index zero or one low.
// - Every 8-bit-operand move gets a 16-bit address using the page; off-chip in split mode without bank select the page is not driven.
// - Pins are claimed only during an off-chip move, then released.
// - Pins acting as inputs have their drivers disabled during a move.
// - Output mode of the pins is never touched by this block.
// - Interface occupies ports 3 to 6 only.
// - Off-chip moves are refused while the segment display is enabled.
// - Multiplexed or non-multiplexed bus style is selectable.
// - Four memory modes: on-chip, split, split with bank, off-chip.
// - Off-chip setup, strobe, hold and latch widths are programmable.
// - Page value N selects addresses N*256 to N*256+255; resets zero.
`timescale 1ns/100ps
`include "emi_map.svh"

module emi_top
  import emi_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] p6_in,
  output emi_pin_t p3_pin,
  output emi_pin_t p4_pin,
  output emi_pin_t p5_pin,
  output emi_pin_t p6_pin,
  output logic pins_owned
);

  //////////////////////////////////////////////////////////////////////////
  // Functions

  // Byte lane merge for narrow registers
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) begin
      r[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      r[15:8] = wd[15:8];
    end
    return r;
  endfunction : merge16

  function automatic logic [15:0] eff_addr(input emi_form_t form,
                                           input logic [15:0] ptr,
                                           input logic [7:0] page,
                                           input logic [7:0] i0,
                                           input logic [7:0] i1);
    logic [15:0] a;
    a = ptr;
    if (form == EMI_FORM_IDX0) begin
      a = {page, i0};
    end else if (form == EMI_FORM_IDX1) begin
      a = {page, i1};
    end
    return a;
  endfunction : eff_addr

  function automatic logic is_offchip(input emi_mode_t mode,
                                      input logic [15:0] a);
    logic r;
    r = 1'b0;
    if (mode == EMI_MM_OFFCHIP) begin
      r = 1'b1;
    end else if (mode != EMI_MM_ONCHIP) begin
      r = (a >= `EMI_ONCHIP_TOP);
    end
    return r;
  endfunction : is_offchip

  //////////////////////////////////////////////////////////////////////////
  // Bus slave and software registers

  logic awready_reg, awready_next, wready_reg, wready_next;
  logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
  logic [7:0] awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next;
  logic [3:0] wstrb_reg, wstrb_next;
  logic bvalid_reg, bvalid_next, arready_reg, arready_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [7:0] page_reg, page_next, ptr_hi_reg, ptr_hi_next;
  logic [7:0] ptr_lo_reg, ptr_lo_next, idx0_reg, idx0_next;
  logic [7:0] idx1_reg, idx1_next;
  logic [`EMI_CFG_W-1:0] cfg_reg, cfg_next;
  logic refused_reg, refused_next;
  logic last_off_reg, last_off_next;
  logic [7:0] rd_byte_reg, rd_byte_next;
  logic do_write, cmd_go, busy;
  emi_move_t start_mv;
  emi_mode_t mode;
  emi_state_t state_reg, state_next;
  logic [7:0] mem_rdata;
  logic cap_valid;
  logic [7:0] cap_data;

  assign mode = emi_mode_t'(cfg_reg[`EMI_CFG_MODE_LO +: 2]);
  assign busy = (state_reg != EMI_IDLE);
  assign do_write = aw_have_reg && w_have_reg && !bvalid_reg;

  always_comb begin
    logic [15:0] a, m16;
    emi_form_t f;
    a = 16'h0000;
    m16 = merge16({2'b00, cfg_reg}, wdata_reg, wstrb_reg);
    f = emi_form_t'(wdata_reg[`EMI_CMD_FORM_LO +: 2]);
    awready_next = awready_reg;
    wready_next = wready_reg;
    aw_have_next = aw_have_reg;
    w_have_next = w_have_reg;
    awaddr_next = awaddr_reg;
    wdata_next = wdata_reg;
    wstrb_next = wstrb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    arready_next = arready_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    page_next = page_reg;
    ptr_hi_next = ptr_hi_reg;
    ptr_lo_next = ptr_lo_reg;
    idx0_next = idx0_reg;
    idx1_next = idx1_reg;
    cfg_next = cfg_reg;
    refused_next = refused_reg;
    cmd_go = 1'b0;
    start_mv = '0;
    // Address and data may arrive in either order
    if (s_axi_awvalid && awready_reg) begin
      aw_have_next = 1'b1;
      awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_reg) begin
      w_have_next = 1'b1;
      wdata_next = s_axi_wdata;
      wstrb_next = s_axi_wstrb;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (do_write) begin
      aw_have_next = 1'b0;
      w_have_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = 2'h0;
      if (awaddr_reg == `EMI_OFF_PAGE) begin
        if (wstrb_reg[0]) begin
          page_next = wdata_reg[7:0];
        end
      end else if (awaddr_reg == `EMI_OFF_PTR_HI) begin
        if (wstrb_reg[0]) begin
          ptr_hi_next = wdata_reg[7:0];
        end
      end else if (awaddr_reg == `EMI_OFF_PTR_LO) begin
        if (wstrb_reg[0]) begin
          ptr_lo_next = wdata_reg[7:0];
        end
      end else if (awaddr_reg == `EMI_OFF_IDX0) begin
        if (wstrb_reg[0]) begin
          idx0_next = wdata_reg[7:0];
        end
      end else if (awaddr_reg == `EMI_OFF_IDX1) begin
        if (wstrb_reg[0]) begin
          idx1_next = wdata_reg[7:0];
        end
      end else if (awaddr_reg == `EMI_OFF_CFG) begin
        cfg_next = m16[`EMI_CFG_W-1:0];
      end else if (awaddr_reg == `EMI_OFF_CMD) begin
        // Command needs both low lanes to be meaningful
        if (wstrb_reg[1:0] == 2'b11) begin
          a = eff_addr(f, {ptr_hi_reg, ptr_lo_reg}, page_reg,
                       idx0_reg, idx1_reg);
          start_mv.addr = a;
          start_mv.write = wdata_reg[`EMI_CMD_DIR];
          start_mv.wdata = wdata_reg[7:0];
          start_mv.offchip = is_offchip(mode, a);
          // Bank select absent: 8-bit form leaves the high lines alone
          start_mv.drive_hi = (f == EMI_FORM_PTR) ||
                              (mode != EMI_MM_SPLIT_NOBANK);
          if (busy || (start_mv.offchip && cfg_reg[`EMI_CFG_LCD])) begin
            refused_next = 1'b1;
          end else begin
            cmd_go = 1'b1;
          end
        end
      end else if (awaddr_reg == `EMI_OFF_STAT) begin
        // Write one clears; a refusal needs a command write, so none lands in the same cycle
        if (wstrb_reg[0] && wdata_reg[`EMI_ST_REFUSED]) begin
          refused_next = 1'b0;
        end
      end else begin
        bresp_next = 2'h2;
      end
    end
    awready_next = !aw_have_next && !bvalid_next;
    wready_next = !w_have_next && !bvalid_next;
    if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (s_axi_arvalid && arready_reg) begin
      rvalid_next = 1'b1;
      rresp_next = 2'h0;
      rdata_next = 32'h0000_0000;
      if (s_axi_araddr == `EMI_OFF_PAGE) begin
        rdata_next[7:0] = page_reg;
      end else if (s_axi_araddr == `EMI_OFF_PTR_HI) begin
        rdata_next[7:0] = ptr_hi_reg;
      end else if (s_axi_araddr == `EMI_OFF_PTR_LO) begin
        rdata_next[7:0] = ptr_lo_reg;
      end else if (s_axi_araddr == `EMI_OFF_IDX0) begin
        rdata_next[7:0] = idx0_reg;
      end else if (s_axi_araddr == `EMI_OFF_IDX1) begin
        rdata_next[7:0] = idx1_reg;
      end else if (s_axi_araddr == `EMI_OFF_CFG) begin
        rdata_next[`EMI_CFG_W-1:0] = cfg_reg;
      end else if (s_axi_araddr == `EMI_OFF_CMD) begin
        rdata_next = 32'h0000_0000;
      end else if (s_axi_araddr == `EMI_OFF_STAT) begin
        rdata_next[`EMI_ST_BUSY] = busy;
        rdata_next[`EMI_ST_OFF] = last_off_reg;
        rdata_next[`EMI_ST_REFUSED] = refused_reg;
        rdata_next[`EMI_ST_RDATA_LO +: 8] = rd_byte_reg;
      end else begin
        rresp_next = 2'h2;
      end
    end
    arready_next = !rvalid_next;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= 2'h0;
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rresp_reg <= 2'h0;
      rdata_reg <= 32'h0000_0000;
      page_reg <= `EMI_PAGE_RST;
      ptr_hi_reg <= 8'h00;
      ptr_lo_reg <= 8'h00;
      idx0_reg <= 8'h00;
      idx1_reg <= 8'h00;
      cfg_reg <= `EMI_CFG_RST;
      refused_reg <= 1'b0;
    end else begin
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      aw_have_reg <= aw_have_next;
      w_have_reg <= w_have_next;
      awaddr_reg <= awaddr_next;
      wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
      page_reg <= page_next;
      ptr_hi_reg <= ptr_hi_next;
      ptr_lo_reg <= ptr_lo_next;
      idx0_reg <= idx0_next;
      idx1_reg <= idx1_next;
      cfg_reg <= cfg_next;
      refused_reg <= refused_next;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

  //////////////////////////////////////////////////////////////////////////
  // Move sequencer and pins

  emi_move_t mv_reg, mv_next;
  logic [3:0] cnt_reg, cnt_next;
  emi_pin_t p3_reg, p3_next, p4_reg, p4_next;
  emi_pin_t p5_reg, p5_next, p6_reg, p6_next;
  logic own_reg, own_next;

  emi_onchip_xdata_ram u_onchip_xdata_ram (
    .clk(clk),
    .arst_n(arst_n),
    .en(state_reg == EMI_ON_ACC),
    .we(mv_reg.write),
    .addr(mv_reg.addr[`EMI_ONCHIP_XDATA_RAM_AW-1:0]),
    .wdata(mv_reg.wdata),
    .rdata(mem_rdata)
  );

  always_comb begin
    logic mux;
    logic [3:0] pulse, setup, hold, alew;
    mux = cfg_reg[`EMI_CFG_MUX];
    pulse = cfg_reg[`EMI_CFG_PULSE_LO +: 4];
    setup = {2'b00, cfg_reg[`EMI_CFG_SETUP_LO +: 2]};
    hold = {2'b00, cfg_reg[`EMI_CFG_HOLD_LO +: 2]};
    alew = {2'b00, cfg_reg[`EMI_CFG_ALE_LO +: 2]};
    state_next = state_reg;
    mv_next = mv_reg;
    cnt_next = cnt_reg;
    cap_valid = 1'b0;
    cap_data = 8'h00;
    case (state_reg)
      EMI_IDLE: begin
        if (cmd_go) begin
          mv_next = start_mv;
          if (!start_mv.offchip) begin
            state_next = EMI_ON_ACC;
          end else if (mux) begin
            state_next = EMI_ALE;
            cnt_next = alew;
          end else begin
            state_next = EMI_SETUP;
            cnt_next = setup;
          end
        end
      end
      EMI_ON_ACC: begin
        state_next = EMI_ON_WAIT;
      end
      EMI_ON_WAIT: begin
        cap_valid = !mv_reg.write;
        cap_data = mem_rdata;
        state_next = EMI_IDLE;
      end
      EMI_ALE: begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h0) begin
          state_next = EMI_ALE_HOLD;
        end
      end
      EMI_ALE_HOLD: begin
        state_next = EMI_SETUP;
        cnt_next = setup;
      end
      EMI_SETUP: begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h0) begin
          state_next = EMI_STROBE;
          cnt_next = pulse;
        end
      end
      EMI_STROBE: begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h0) begin
          // Sample at the last strobe cycle, data is settled by then
          cap_valid = !mv_reg.write;
          cap_data = p6_in;
          state_next = EMI_HOLD;
          cnt_next = hold;
        end
      end
      EMI_HOLD: begin
        cnt_next = cnt_reg - 4'h1;
        if (cnt_reg == 4'h0) begin
          state_next = EMI_IDLE;
        end
      end
      default: begin
        state_next = EMI_IDLE;
      end
    endcase
  end

  always_comb begin
    logic off_next;
    off_next = (state_next != EMI_IDLE) && (state_next != EMI_ON_ACC) &&
               (state_next != EMI_ON_WAIT);
    rd_byte_next = cap_valid ? cap_data : rd_byte_reg;
    last_off_next = cmd_go ? start_mv.offchip : last_off_reg;
    own_next = off_next;
    // Released pins: drivers off, port latches take over
    p3_next = '{dout: `EMI_PIN_PARK, oe_n: 8'hFF};
    p4_next = '{dout: `EMI_PIN_PARK, oe_n: 8'hFF};
    p5_next = '{dout: `EMI_PIN_PARK, oe_n: 8'hFF};
    p6_next = '{dout: `EMI_PIN_PARK, oe_n: 8'hFF};
    // Only enables and levels here, pin drive mode stays outside
    if (off_next) begin
      p3_next.oe_n[`EMI_P3_RD] = 1'b0;
      p3_next.oe_n[`EMI_P3_WR] = 1'b0;
      p3_next.dout[`EMI_P3_RD] =
        !(state_next == EMI_STROBE && !mv_next.write);
      p3_next.dout[`EMI_P3_WR] =
        !(state_next == EMI_STROBE && mv_next.write);
      if (cfg_reg[`EMI_CFG_MUX]) begin
        p3_next.oe_n[`EMI_P3_ALE] = 1'b0;
        p3_next.dout[`EMI_P3_ALE] = (state_next == EMI_ALE);
        if (mv_next.drive_hi) begin
          p5_next = '{dout: mv_next.addr[15:8], oe_n: 8'h00};
        end
        if (state_next == EMI_ALE || state_next == EMI_ALE_HOLD) begin
          p6_next = '{dout: mv_next.addr[7:0], oe_n: 8'h00};
        end else if (mv_next.write) begin
          p6_next = '{dout: mv_next.wdata, oe_n: 8'h00};
        end
      end else begin
        p5_next = '{dout: mv_next.addr[7:0], oe_n: 8'h00};
        if (mv_next.drive_hi) begin
          p4_next = '{dout: mv_next.addr[15:8], oe_n: 8'h00};
        end
        if (mv_next.write) begin
          p6_next = '{dout: mv_next.wdata, oe_n: 8'h00};
        end
      end
      // Read: data lines stay released so the device can drive
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= EMI_IDLE;
      mv_reg <= '0;
      cnt_reg <= 4'h0;
      rd_byte_reg <= 8'h00;
      last_off_reg <= 1'b0;
      own_reg <= 1'b0;
      p3_reg <= '{dout: `EMI_PIN_PARK, oe_n: 8'hFF};
      p4_reg <= '{dout: `EMI_PIN_PARK, oe_n: 8'hFF};
      p5_reg <= '{dout: `EMI_PIN_PARK, oe_n: 8'hFF};
      p6_reg <= '{dout: `EMI_PIN_PARK, oe_n: 8'hFF};
    end else begin
      state_reg <= state_next;
      mv_reg <= mv_next;
      cnt_reg <= cnt_next;
      rd_byte_reg <= rd_byte_next;
      last_off_reg <= last_off_next;
      own_reg <= own_next;
      p3_reg <= p3_next;
      p4_reg <= p4_next;
      p5_reg <= p5_next;
      p6_reg <= p6_next;
    end
  end

  assign p3_pin = p3_reg;
  assign p4_pin = p4_reg;
  assign p5_pin = p5_reg;
  assign p6_pin = p6_reg;
  assign pins_owned = own_reg;

endmodule : emi_top

// >>> sim/emi_props.sv
/* Pin-side checker of emi_top.
   Assumes binding to emi_top and sees its ports only. */
`timescale 1ns/100ps
module emi_props
  import emi_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire emi_pin_t p3_pin,
  input wire emi_pin_t p6_pin,
  input wire logic pins_owned
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////////////////
  // Two idle cycles, though pin outputs and the owned flag register on the same edge
  sequence s_idle2;
    !pins_owned && !$past(pins_owned);
  endsequence
  sequence s_handback;
    ##[1:40] !pins_owned;
  endsequence
  property p_park;
    s_idle2 |-> p3_pin.oe_n == 8'hFF && p6_pin.oe_n == 8'hFF;
  endproperty
  property p_strb_idle;
    s_idle2 |-> p3_pin.dout[7:6] == 2'h3;
  endproperty
  property p_one_strb;
    p3_pin.dout[6] || p3_pin.dout[7];
  endproperty
  property p_rd_in;
    !p3_pin.dout[6] |-> p6_pin.oe_n == 8'hFF;
  endproperty
  property p_wr_out;
    !p3_pin.dout[7] |-> p6_pin.oe_n == 8'h00;
  endproperty
  property p_strb_owned;
    !(p3_pin.dout[6] && p3_pin.dout[7]) |-> pins_owned;
  endproperty
  property p_ale;
    $fell(p3_pin.dout[5]) && !p3_pin.oe_n[5]
      |-> p6_pin.oe_n == 8'h00 && $stable(p6_pin.dout);
  endproperty
  property p_owned_end;
    $rose(pins_owned) |-> s_handback;
  endproperty
  a_park: assert property (p_park)
    else $error("pins not released while idle");
  a_strb_idle: assert property (p_strb_idle)
    else $error("strobe active while idle");
  a_one_strb: assert property (p_one_strb)
    else $error("both strobes active");
  a_rd_in: assert property (p_rd_in)
    else $error("data drivers on during read strobe");
  a_wr_out: assert property (p_wr_out)
    else $error("data not driven during write strobe");
  a_strb_owned: assert property (p_strb_owned)
    else $error("strobe outside an owned move");
  a_ale: assert property (p_ale)
    else $error("address not held after latch strobe");
  a_owned_end: assert property (p_owned_end)
    else $error("pins not handed back in time");
endmodule : emi_props
bind emi_top emi_props u_props (.clk(clk), .arst_n(arst_n),
  .p3_pin(p3_pin), .p6_pin(p6_pin), .pins_owned(pins_owned));

// >>> sim/emi_sram.sv
/* Behavioural off-chip byte memory on ports 3 to 6.
   Assumes mux tells the bus style that the bench configured. */
`timescale 1ns/100ps
module emi_sram
  import emi_pkg::*;
(
  input wire logic clk,
  input wire logic mux,
  input wire emi_pin_t p3_pin,
  input wire emi_pin_t p4_pin,
  input wire emi_pin_t p5_pin,
  input wire emi_pin_t p6_pin,
  output logic [7:0] p6_in
);
  logic [7:0] mem [0:65535];
  logic [7:0] lat_reg;
  logic [7:0] last_reg;
  logic [15:0] addr;
  assign addr = mux ? {p5_pin.dout, lat_reg} : {p4_pin.dout, p5_pin.dout};
  logic rd_n, wr_n;
  // Released strobe pins read the parked port latch level, high
  assign rd_n = p3_pin.oe_n[6] | p3_pin.dout[6];
  assign wr_n = p3_pin.oe_n[7] | p3_pin.dout[7];
  always_ff @(posedge clk) begin
    if (!p3_pin.oe_n[5] && p3_pin.dout[5]) begin
      lat_reg <= p6_pin.dout;
    end
    if (!wr_n) begin
      mem[addr] <= p6_pin.dout;
    end
    if (!rd_n) begin
      last_reg <= mem[addr];
    end
  end
  // Digital levels in; a released bus shows the inverse, never a stale byte
  assign p6_in = !rd_n ? mem[addr] : ~last_reg;
endmodule : emi_sram

// >>> sim/tb.sv
/* Self-checking bench of emi_top with an off-chip memory model.
   Assumes the map header on the include path. */
`timescale 1ns/100ps
`include "emi_map.svh"
module tb;
  import emi_pkg::*;
  logic clk, arst_n, awv, awr, wv, wrd, bv, bre, arv, arr, rv, rre, mux;
  logic [7:0] awa, ara, p6_in;
  logic [31:0] wd, rdat, rdv, st;
  logic [3:0] ws;
  logic [1:0] br, rr, rrs, brs;
  emi_pin_t p3, p4, p5, p6;
  logic po, seen;
  int num_errors, n_tests, rcnt;
  emi_top uut (.clk(clk), .arst_n(arst_n), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rre), .p6_in(p6_in), .p3_pin(p3), .p4_pin(p4),
    .p5_pin(p5), .p6_pin(p6), .pins_owned(po));
  emi_sram u_sram (.clk(clk), .mux(mux), .p3_pin(p3), .p4_pin(p4),
    .p5_pin(p5), .p6_pin(p6), .p6_in(p6_in));
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (po) seen <= 1'b1;
    if (p3.dout[6] === 1'b0) rcnt <= rcnt + 1;
  end
  task automatic conclude;
    if (num_errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // A spent bound counts as a fault and ends the run
  task automatic tmo(input int i);
    if (i >= 60) begin
      num_errors++;
      $display("mismatch timeout exp %0d got %0d", 60, i);
      conclude();
    end
  endtask : tmo
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bre <= 1'b1;
    for (i = 0; i < 60 && (awv || wv || !bv); i++) begin
      @(posedge clk);
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end
    tmo(i);
    brs = br;
    bre <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    int i;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rre <= 1'b1;
    for (i = 0; i < 60 && (arv || !rv); i++) begin
      @(posedge clk);
      if (arr) arv <= 1'b0;
    end
    tmo(i);
    rdv = rdat;
    rrs = rr;
    rre <= 1'b0;
  endtask : rd
  task automatic mv(input logic [1:0] f, input logic w, input logic [7:0] d);
    int i;
    wr(`EMI_OFF_CMD, {21'h0, f, w, d});
    for (i = 0; i < 60; i++) begin
      rd(`EMI_OFF_STAT);
      if (rdv[0] === 1'b0) break;
    end
    tmo(i);
    st = rdv;
  endtask : mv
  ////////////////////////////////////////////////////////////////////////
  task automatic t_onchip;
    int f;
    wr(`EMI_OFF_CFG, 32'h0);
    wr(`EMI_OFF_PTR_HI, 32'h12);
    wr(`EMI_OFF_PTR_LO, 32'h34);
    wr(`EMI_OFF_PAGE, 32'h12);
    wr(`EMI_OFF_IDX0, 32'h34);
    wr(`EMI_OFF_IDX1, 32'h56);
    rd(`EMI_OFF_PTR_HI);
    chk("ptr hi", 32'h12, rdv);
    seen = 1'b0;
    mv(2'h0, 1'b1, 8'h5A);
    mv(2'h2, 1'b1, 8'hC3);
    for (f = 0; f < 4; f++) begin
      mv(f[1:0], 1'b0, 8'h00);
      chk("onchip rd", f == 2 ? 32'hC3 : 32'h5A,
          {24'h0, st[15:8]});
    end
    chk("stayed", 32'h0, {31'h0, seen | st[1]});
  endtask : t_onchip
  task automatic t_offchip;
    int m;
    for (m = 0; m < 2; m++) begin
      mux <= m[0];
      wr(`EMI_OFF_CFG, 32'h1526 | m);
      wr(`EMI_OFF_PTR_HI, 32'hAB);
      wr(`EMI_OFF_PTR_LO, {24'h0, 7'h60, m[0]});
      mv(2'h0, 1'b1, 8'h96);
      chk("sram", 32'h96, {24'h0, u_sram.mem[{15'h55E0, m[0]}]});
      rcnt = 0;
      mv(2'h0, 1'b0, 8'h00);
      chk("off rd", 32'h96, {24'h0, st[15:8]});
      chk("strobe len", 32'h3, rcnt);
    end
    mux <= 1'b0;
  endtask : t_offchip
  task automatic t_split;
    int m;
    int h;
    for (m = 0; m < 4; m++) begin
      for (h = 1; h < 4; h += 2) begin
        wr(`EMI_OFF_CFG, 32'h1520 | (m << 1));
        wr(`EMI_OFF_PTR_HI, h << 4);
        mv(2'h0, 1'b0, 8'h00);
        chk("route", (m == 3 || (m != 0 && h == 3)) ? 32'h1 : 32'h0,
            {31'h0, st[1]});
      end
    end
  endtask : t_split
  task automatic t_refuse;
    wr(`EMI_OFF_CFG, 32'h152E);
    seen = 1'b0;
    mv(2'h0, 1'b1, 8'h11);
    chk("refused", 32'h1, {31'h0, st[2] & !seen});
    wr(`EMI_OFF_STAT, 32'h4);
    rd(`EMI_OFF_STAT);
    chk("cleared", 32'h0, {31'h0, rdv[2]});
    rd(8'h40);
    chk("unmapped", 32'h2, {rdv[29:0], rrs});
    wr(8'h40, 32'h0);
    chk("bresp", 32'h2, {30'h0, brs});
  endtask : t_refuse
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {arst_n, awv, wv, bre, arv, rre, mux, seen, awa, ara, wd} = '0;
    ws = 4'hF;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    rd(`EMI_OFF_PAGE);
    chk("page", 32'h0, rdv);
    chk("p6 oe", 32'hFF, {24'h0, p6.oe_n});
    t_onchip();
    t_offchip();
    t_split();
    t_refuse();
    conclude();
  end
endmodule : tb
